// *** hdl/host_port_pin_control.sv ***
// Host port pin control: pin sharing, modes, ready, host interrupts, port reset
//
// What this block does
// - Shared pins serve host port only when select low
// - Ready tells host when next transfer allowed
// - Ready floats while output disable low
// - Host interrupt asserted by driving output low
// - Host writing one to irq bit clears it
// - Host interrupts only in multiplexed mode
// - Interrupt outputs float while output disable low
// - Port reset clears port logic and both subsystems
// - Mode select low gives multiplexed address/data
// - Multiplexed host reaches control, address, data registers
// - Mode select high gives separate address/data buses
// - Separate mode: 18-bit address, 16-bit data
`timescale 1ns/1ps
`include "host_port_cfg.svh"
module host_port_pin_control import host_port_pkg::*; #(
    parameter int HADDR_W = `HADDR_W,
    parameter int HDATA_W = `HDATA_W
) (
    input wire logic clk,
    input wire logic nrst,
    // AXI4-Lite slave
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic irq,
    // Host pins
    input wire host_ctl_type hostCtl,
    input wire logic [HADDR_W-1:0] hostAddrIn,
    input wire logic [HDATA_W-1:0] hostDataIn,
    output logic [HDATA_W-1:0] hostDataOut,
    output logic hostDataOe,
    output host_drv_type hostDrv,
    // Subsystem side
    input wire logic irqReqSubA,
    input wire logic irqReqSubB,
    output logic subResetN
);

    // ------------------------------------------------------------
    // Pin decode
    // ------------------------------------------------------------
    logic portActive;
    logic muxMode;
    logic strobe;
    logic strobe_r;
    logic strobeRise;
    logic strobeFall;
    logic portReset;
    // Strobe active while both low is the only combination
    assign portActive = !hostCtl.interfaceSelect;
    assign muxMode = !hostCtl.hostModeSelect;
    assign strobe = portActive && !(hostCtl.hostStrobeOne ^ hostCtl.hostStrobeTwo)
        && !hostCtl.hostStrobeOne;
    assign strobeRise = strobe && !strobe_r;
    assign strobeFall = !strobe && strobe_r;
    assign portReset = !hostCtl.portResetInN;

    // Strobe edge history
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            strobe_r <= 1'b0;
        end else begin
            strobe_r <= strobe;
        end
    end

    // Subsystems held in reset with the port, as the host expects
    assign subResetN = nrst && !portReset;

    // ------------------------------------------------------------
    // Transfer sequencing and ready
    // ------------------------------------------------------------
    xfer_state_type xferState_r;
    logic [`CTRL_ACCESS_WAIT_W-1:0] waitCnt_r;
    logic [`CTRL_ACCESS_WAIT_W-1:0] accessWait_r;
    logic xferDone;
    logic isWrite;
    logic [1:0] hostReg;
    assign isWrite = !hostCtl.hostDirectionIn;
    // Multiplexed hosts pick the register by low address bits; separate mode is data only
    assign hostReg = muxMode ? hostAddrIn[1:0] : `HREG_DATA;
    assign xferDone = (xferState_r == XF_ACCESS) && (waitCnt_r == '0);

    // Internal access takes a programmable number of cycles
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            xferState_r <= XF_IDLE;
            waitCnt_r <= '0;
        end else if (portReset) begin
            xferState_r <= XF_IDLE;
            waitCnt_r <= '0;
        end else begin
            unique case (xferState_r)
                XF_IDLE: begin
                    if (strobeRise) begin
                        xferState_r <= XF_ACCESS;
                        waitCnt_r <= accessWait_r;
                    end
                end
                XF_ACCESS: begin
                    if (waitCnt_r != '0) begin
                        waitCnt_r <= waitCnt_r - 1'b1;
                    end else begin
                        xferState_r <= strobe ? XF_WAIT_END : XF_IDLE;
                    end
                end
                XF_WAIT_END: begin
                    if (!strobe) begin
                        xferState_r <= XF_IDLE;
                    end
                end
            endcase
        end
    end

    // Ready low while access pending; floats when outputs disabled
    always_comb begin
        hostDrv.readyOut = (xferState_r != XF_ACCESS) && !portReset;
        hostDrv.readyOe = portActive && hostCtl.outputDisableN;
    end

    // ------------------------------------------------------------
    // Host visible registers
    // ------------------------------------------------------------
    logic [HDATA_W-1:0] portAddr_r;
    logic [HDATA_W-1:0] portData_r;
    logic [HDATA_W-1:0] hostRdata_r;
    logic pendA_r;
    logic pendB_r;
    logic hostClrA;
    logic hostClrB;
    logic ctrlWr;
    assign ctrlWr = xferDone && isWrite && muxMode && hostReg == `HREG_CTRL;
    assign hostClrA = ctrlWr && hostDataIn[`PCTRL_IRQ_BIT] && !hostDataIn[`PCTRL_SUB_BIT];
    assign hostClrB = ctrlWr && hostDataIn[`PCTRL_IRQ_BIT] && hostDataIn[`PCTRL_SUB_BIT];

    // Address and data holding registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            portAddr_r <= '0;
            portData_r <= '0;
        end else if (portReset) begin
            portAddr_r <= '0;
            portData_r <= '0;
        end else if (xferDone && isWrite) begin
            if (hostReg == `HREG_ADDR) begin
                portAddr_r <= hostDataIn;
            end
            if (hostReg == `HREG_DATA) begin
                portData_r <= hostDataIn;
            end
        end
    end

    // Read data captured at access end, driven while strobe held
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hostRdata_r <= '0;
            hostDataOe <= 1'b0;
        end else begin
            if (xferDone && !isWrite) begin
                unique case (hostReg)
                    `HREG_CTRL: hostRdata_r <= HDATA_W'({pendB_r, pendA_r}) << `PCTRL_IRQ_BIT;
                    `HREG_ADDR: hostRdata_r <= portAddr_r;
                    default: hostRdata_r <= portData_r;
                endcase
            end
            hostDataOe <= strobe && !isWrite && !portReset && hostCtl.outputDisableN;
        end
    end
    assign hostDataOut = hostRdata_r;

    // Per-subsystem interrupt pending; a new request wins over a clear
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pendA_r <= 1'b0;
            pendB_r <= 1'b0;
        end else if (portReset || !muxMode) begin
            pendA_r <= 1'b0;
            pendB_r <= 1'b0;
        end else begin
            pendA_r <= irqReqSubA || (pendA_r && !hostClrA);
            pendB_r <= irqReqSubB || (pendB_r && !hostClrB);
        end
    end

    // Interrupt pins active low, floated on output disable
    always_comb begin
        hostDrv.irqSubAOut = !pendA_r;
        hostDrv.irqSubBOut = !pendB_r;
        hostDrv.irqSubAOe = portActive && hostCtl.outputDisableN;
        hostDrv.irqSubBOe = portActive && hostCtl.outputDisableN;
    end

    // ------------------------------------------------------------
    // Software status and interrupt
    // ------------------------------------------------------------
    logic [`ST_W-1:0] status_r;
    logic [`ST_W-1:0] mask_r;
    logic [`ST_W-1:0] events;
    logic statusRead;
    logic portReset_r;
    assign events = {hostClrB, hostClrA, portReset && !portReset_r, xferDone};

    // Reset edge history
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            portReset_r <= 1'b0;
        end else begin
            portReset_r <= portReset;
        end
    end

    // Sticky, cleared by read; an event in the read cycle survives
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            status_r <= '0;
        end else begin
            status_r <= events | (statusRead ? '0 : status_r);
        end
    end
    assign irq = |(status_r & mask_r);

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    logic awHeld_r;
    logic wHeld_r;
    logic [7:0] awAddr_r;
    logic [31:0] wData_r;
    logic doWrite;
    assign awready = !awHeld_r && !bvalid;
    assign wready = !wHeld_r && !bvalid;
    assign doWrite = awHeld_r && wHeld_r && !bvalid;
    assign arready = !rvalid;
    assign statusRead = arvalid && arready && araddr == `OFF_STATUS;

    // Write address and data taken in either order
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
            awAddr_r <= '0;
            wData_r <= '0;
            bvalid <= 1'b0;
            bresp <= 2'b00;
        end else begin
            if (awvalid && awready) begin
                awHeld_r <= 1'b1;
                awAddr_r <= awaddr;
            end
            if (wvalid && wready) begin
                wHeld_r <= 1'b1;
                wData_r <= wdata;
            end
            if (doWrite) begin
                awHeld_r <= 1'b0;
                wHeld_r <= 1'b0;
                bvalid <= 1'b1;
                bresp <= (awAddr_r == `OFF_CTRL || awAddr_r == `OFF_MASK) ? 2'b00 : 2'b10;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // Writable registers; strobe byte 0 only matters at this width
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            accessWait_r <= `CTRL_ACCESS_WAIT_W'(`CTRL_RST);
            mask_r <= `MASK_RST;
        end else if (doWrite && wstrb[0]) begin
            if (awAddr_r == `OFF_CTRL) begin
                accessWait_r <= wData_r[`CTRL_ACCESS_WAIT_LSB +: `CTRL_ACCESS_WAIT_W];
            end
            if (awAddr_r == `OFF_MASK) begin
                mask_r <= wData_r[`ST_W-1:0];
            end
        end
    end

    // Read channel, one cycle answer
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= 2'b00;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rresp <= 2'b00;
            unique case (araddr)
                `OFF_CTRL: rdata <= 32'(accessWait_r);
                `OFF_STATUS: rdata <= 32'(status_r);
                `OFF_MASK: rdata <= 32'(mask_r);
                `OFF_IRQREQ: rdata <= 32'({pendB_r, pendA_r});
                `OFF_PINSTAT: rdata <= 32'({xferState_r, muxMode, portActive});
                default: begin
                    rdata <= '0;
                    rresp <= 2'b10;
                end
            endcase
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end

endmodule : host_port_pin_control

// *** common/host_port_cfg.svh ***
// Offsets, field positions, reset values and timing counts of the host port
`ifndef HOST_PORT_CFG_SVH
`define HOST_PORT_CFG_SVH
// AXI4-Lite register byte offsets
`define OFF_CTRL 8'h00
`define OFF_STATUS 8'h04
`define OFF_MASK 8'h08
`define OFF_IRQREQ 8'h0C
`define OFF_PINSTAT 8'h10
// Control register fields
`define CTRL_ACCESS_WAIT_LSB 0
`define CTRL_ACCESS_WAIT_W 4
`define CTRL_RST 16'h0002
// Status and mask bits
`define ST_XFER 0
`define ST_PORT_RST 1
`define ST_CLR_A 2
`define ST_CLR_B 3
`define ST_W 4
`define MASK_RST 4'h0
// Port control register fields seen by the host
`define PCTRL_IRQ_BIT 2
`define PCTRL_SUB_BIT 3
// Host address ranges
`define HADDR_W 18
`define HDATA_W 16
`define HREG_CTRL 2'h0
`define HREG_ADDR 2'h1
`define HREG_DATA 2'h2
`endif

// *** common/host_port_pkg.sv ***
// Types shared by the host port pin control
package host_port_pkg;
    typedef struct packed {
        logic interfaceSelect;
        logic hostModeSelect;
        logic outputDisableN;
        logic portResetInN;
        logic hostDirectionIn;
        logic hostStrobeOne;
        logic hostStrobeTwo;
        logic addrLatchN;
    } host_ctl_type;
    typedef struct packed {
        logic readyOut;
        logic readyOe;
        logic irqSubAOut;
        logic irqSubAOe;
        logic irqSubBOut;
        logic irqSubBOe;
    } host_drv_type;
    typedef enum logic [1:0] {
        XF_IDLE,
        XF_ACCESS,
        XF_WAIT_END
    } xfer_state_type;
endpackage : host_port_pkg

// *** test/host_port_pin_control_assertions.sv ***
// Checker of the host port pin rules
`timescale 1ns/1ps
module host_port_pin_control_assertions import host_port_pkg::*; (
    input wire logic clk,
    input wire logic nrst,
    input wire host_ctl_type hostCtl,
    input wire host_drv_type hostDrv,
    input wire logic irqReqSubA,
    input wire logic irqReqSubB,
    input wire logic subResetN
);
    // ------------------
    // Pin rules
    // ------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    logic stb;
    logic live;
    // Strobe counts only with both lines low
    assign stb = !hostCtl.hostStrobeOne && !hostCtl.hostStrobeTwo;
    assign live = !hostCtl.interfaceSelect && hostCtl.portResetInN;
    sequence accessDone;
        !hostDrv.readyOut ##[1:40] hostDrv.readyOut;
    endsequence
    // Three edges so the forced clear can reach the pins
    sequence sepHeld;
        hostCtl.hostModeSelect [*3];
    endsequence
    ready_busy_a: assert property ($rose(stb) && live |-> ##[1:2] accessDone)
        else $error("ready did not drop and return after a strobe");
    ready_float_a: assert property (!hostCtl.outputDisableN |-> !hostDrv.readyOe)
        else $error("ready driven while outputs disabled");
    irq_float_a: assert property (!hostCtl.outputDisableN |-> !hostDrv.irqSubAOe && !hostDrv.irqSubBOe)
        else $error("interrupt pin driven while outputs disabled");
    pin_share_a: assert property (hostCtl.interfaceSelect |-> !hostDrv.readyOe && !hostDrv.irqSubAOe)
        else $error("host pins driven while memory interface selected");
    sub_reset_a: assert property (!hostCtl.portResetInN |-> !subResetN)
        else $error("subsystems not held in reset");
    reset_ready_a: assert property (!hostCtl.portResetInN [*2] |-> !hostDrv.readyOut)
        else $error("ready high during port reset");
    sep_irq_a: assert property (sepHeld |-> hostDrv.irqSubAOut && hostDrv.irqSubBOut)
        else $error("interrupt asserted in separate mode");
    irq_set_a: assert property (irqReqSubA && !hostCtl.hostModeSelect && hostCtl.portResetInN
        |-> ##[1:2] !hostDrv.irqSubAOut) else $error("first interrupt not asserted");
    irqb_set_a: assert property (irqReqSubB && !hostCtl.hostModeSelect && hostCtl.portResetInN
        |-> ##[1:2] !hostDrv.irqSubBOut) else $error("second interrupt not asserted");
endmodule : host_port_pin_control_assertions
bind host_port_pin_control host_port_pin_control_assertions u_chk (.clk(clk), .nrst(nrst),
    .hostCtl(hostCtl), .hostDrv(hostDrv), .irqReqSubA(irqReqSubA), .irqReqSubB(irqReqSubB),
    .subResetN(subResetN));

// *** test/host_port_host_model.sv ***
// Behavioural external host on the host port pins
`timescale 1ns/1ps
module host_port_host_model import host_port_pkg::*; (
    input wire logic clk,
    input wire host_ctl_type cfgIn,
    input wire host_drv_type hostDrv,
    input wire logic [15:0] hostDataOut,
    input wire logic hostDataOe,
    output host_ctl_type hostCtl,
    output logic [17:0] hostAddrIn,
    output logic [15:0] hostDataIn
);
    // ------------------
    // Host side
    // ------------------
    logic dirRd;
    logic stbN;
    logic [15:0] lastData;
    // Static pins come from the bench, strobes and direction from here
    assign hostCtl = {cfgIn[7:4], dirRd, stbN, stbN, 1'b1};
    initial begin
        dirRd = 1'b1;
        stbN = 1'b1;
        lastData = 16'h0000;
        hostAddrIn = 18'h00000;
        hostDataIn = 16'hFFFF;
    end
    // Pins held until ready returns; released data shows the inverse
    task automatic xfer(input logic rd, input logic [17:0] a, input logic [15:0] wd,
        output logic [15:0] q);
        int n;
        while (hostDrv.readyOut !== 1'b1) @(posedge clk);
        hostAddrIn <= a;
        hostDataIn <= rd ? ~lastData : wd;
        dirRd <= rd;
        stbN <= 1'b0;
        @(posedge clk);
        for (n = 0; n < 4 && hostDrv.readyOut === 1'b1; n++) @(posedge clk);
        while (hostDrv.readyOut !== 1'b1) @(posedge clk);
        @(posedge clk);
        // Undriven data lines read back as the inverse of the last word
        q = (hostDataOe === 1'b1) ? hostDataOut : ~lastData;
        stbN <= 1'b1;
        if (!rd) lastData = wd;
        hostDataIn <= ~lastData;
        @(posedge clk);
    endtask : xfer
endmodule : host_port_host_model

// *** test/test_host_port_pin_control.sv ***
// Self-checking bench for the host port pin control
`timescale 1ns/1ps
`include "host_port_cfg.svh"
module test_host_port_pin_control import host_port_pkg::*;;
    // ------------------
    // Signals and tasks
    // ------------------
    logic clk, nrst, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
    logic arready, rvalid, irq, hostDataOe, irqReqSubA, irqReqSubB, subResetN;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    logic [15:0] hostDataOut, hostDataIn, hd;
    logic [17:0] hostAddrIn;
    host_ctl_type cfg, hostCtl;
    host_drv_type hostDrv;
    int err_total, checks_done;
    host_port_pin_control u_host_port_pin_control (.clk(clk), .nrst(nrst), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .irq(irq), .hostCtl(hostCtl), .hostAddrIn(hostAddrIn),
        .hostDataIn(hostDataIn), .hostDataOut(hostDataOut), .hostDataOe(hostDataOe),
        .hostDrv(hostDrv), .irqReqSubA(irqReqSubA), .irqReqSubB(irqReqSubB),
        .subResetN(subResetN));
    host_port_host_model u_host_port_host_model (.clk(clk), .cfgIn(cfg), .hostDrv(hostDrv),
        .hostDataOut(hostDataOut), .hostDataOe(hostDataOe), .hostCtl(hostCtl),
        .hostAddrIn(hostAddrIn),
        .hostDataIn(hostDataIn));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // Both channels offered together, each released when taken
    task automatic axiWr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] s);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // Waits only on the answer; the watchdog ends a hang
        do begin
            @(posedge clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        s = bresp;
        bready <= 1'b0;
        // One idle edge so a following call never overlaps this one
        @(posedge clk);
    endtask : axiWr
    task automatic axiRd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] s);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        v = rdata;
        s = rresp;
        rready <= 1'b0;
        @(posedge clk);
    endtask : axiRd
    task automatic pulse(input logic b);
        irqReqSubA <= !b;
        irqReqSubB <= b;
        @(posedge clk);
        irqReqSubA <= 1'b0;
        irqReqSubB <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : pulse
    task automatic results;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : results
    // ------------------
    // Tests
    // ------------------
    // Limit far above the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        results();
    end
    initial begin
        {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
        {irqReqSubA, irqReqSubB, nrst} = '0;
        wstrb = 4'hF;
        cfg = 8'h3F;
        err_total = 0;
        checks_done = 0;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        axiRd(`OFF_CTRL, d, r);
        chk(d, {16'h0000, `CTRL_RST});
        axiRd(8'h14, d, r);
        chk({30'h0, r}, 32'h2);
        axiWr(`OFF_PINSTAT, 32'h0, r);
        chk({30'h0, r}, 32'h2);
        axiRd(`OFF_PINSTAT, d, r);
        chk(d[1], 1'b1);
        chk(hostDrv.readyOe, 1'b1);
        // Address register round trip; mask still clear so no irq
        u_host_port_host_model.xfer(1'b0, 18'h00001, 16'hA5C3, hd);
        u_host_port_host_model.xfer(1'b1, 18'h00001, 16'h0000, hd);
        chk(hd, 16'hA5C3);
        chk(irq, 1'b0);
        axiWr(`OFF_MASK, 32'h0000000F, r);
        chk(irq, 1'b1);
        axiRd(`OFF_STATUS, d, r);
        chk(d, 32'h1);
        @(posedge clk);
        chk(irq, 1'b0);
        // Each subsystem raises and the host clears its own line
        for (int s = 0; s < 2; s++) begin
            pulse(s[0]);
            chk(hostDrv.irqSubAOut, s != 0);
            chk(hostDrv.irqSubBOut, s != 1);
            u_host_port_host_model.xfer(1'b0, 18'h00000, s ? 16'h000C : 16'h0004, hd);
            chk({hostDrv.irqSubBOut, hostDrv.irqSubAOut}, 2'b11);
        end
        cfg.outputDisableN <= 1'b0;
        repeat (2) @(posedge clk);
        chk({hostDrv.readyOe, hostDrv.irqSubAOe, hostDrv.irqSubBOe}, 3'b000);
        cfg.outputDisableN <= 1'b1;
        cfg.hostModeSelect <= 1'b1;
        repeat (2) @(posedge clk);
        axiRd(`OFF_PINSTAT, d, r);
        chk(d[1], 1'b0);
        pulse(1'b0);
        chk(hostDrv.irqSubAOut, 1'b1);
        axiRd(`OFF_STATUS, d, r);
        u_host_port_host_model.xfer(1'b0, 18'h2ABCD, 16'h1357, hd);
        axiRd(`OFF_STATUS, d, r);
        chk(d[0], 1'b1);
        u_host_port_host_model.xfer(1'b1, 18'h2ABCD, 16'h0000, hd);
        chk(hd, 16'h1357);
        cfg.hostModeSelect <= 1'b0;
        cfg.interfaceSelect <= 1'b1;
        @(posedge clk);
        u_host_port_host_model.xfer(1'b0, 18'h00001, 16'h1111, hd);
        chk(hostDrv.readyOe, 1'b0);
        cfg.interfaceSelect <= 1'b0;
        @(posedge clk);
        u_host_port_host_model.xfer(1'b1, 18'h00001, 16'h0000, hd);
        chk(hd, 16'hA5C3);
        // Data register reached over the shared lines
        u_host_port_host_model.xfer(1'b0, 18'h00002, 16'h5AA5, hd);
        u_host_port_host_model.xfer(1'b1, 18'h00002, 16'h0000, hd);
        chk(hd, 16'h5AA5);
        // Port reset drops a pending request and the host registers
        pulse(1'b1);
        u_host_port_host_model.xfer(1'b1, 18'h00000, 16'h0000, hd);
        chk(hd, 16'h0008);
        cfg.portResetInN <= 1'b0;
        @(posedge clk);
        #1;
        chk(subResetN, 1'b0);
        repeat (2) @(posedge clk);
        chk(hostDrv.readyOut, 1'b0);
        cfg.portResetInN <= 1'b1;
        repeat (2) @(posedge clk);
        chk(hostDrv.irqSubBOut, 1'b1);
        u_host_port_host_model.xfer(1'b1, 18'h00001, 16'h0000, hd);
        chk(hd, 16'h0000);
        axiRd(`OFF_STATUS, d, r);
        chk(d[1], 1'b1);
        results();
    end
endmodule : test_host_port_pin_control
